// [src/sgo_top.sv]
// Serial GPIO per-bit output values, input capture, interrupt vectors and loss-of-signal
`timescale 1ns/100ps
module sgo_top #(
    parameter int BLINK_HALF_CYCLES = sgo_pkg::BLINK_HALF_CYC,
    parameter int ACT_TICK_CYCLES = sgo_pkg::ACT_TICK_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Output configuration
    input wire sgo_pkg::sgo_bitcfg_t [sgo_pkg::NUM_BITS-1:0] bit_cfg_in,
    input wire logic [1:0] blink_gen0_rate_in,
    input wire logic [1:0] blink_gen1_rate_in,
    input wire logic blink_counter_clear_in,
    input wire logic [sgo_pkg::NUM_PWM-1:0] pwm_in,
    // Engine events and port module activity
    input wire logic burst_done_in,
    input wire logic [sgo_pkg::NUM_MODULES-1:0] rx_activity_in,
    input wire logic [sgo_pkg::NUM_MODULES-1:0] tx_activity_in,
    // Serial input capture
    input wire logic serial_data_in,
    input wire sgo_pkg::sgo_sample_t sample_in,
    // Interrupt configuration
    input wire logic [sgo_pkg::NUM_BITS-1:0] input_polarity_vector_in,
    input wire logic [sgo_pkg::NUM_BITS-1:0] trigger_select_lo_in,
    input wire logic [sgo_pkg::NUM_BITS-1:0] trigger_select_hi_in,
    input wire logic [sgo_pkg::NUM_PORTS-1:0] port_irq_enable_in,
    input wire logic [sgo_pkg::BITS_PER_PORT-1:0] position_irq_enable_in,
    input wire logic sticky_clear_we_in,
    input wire logic [sgo_pkg::NUM_BITS-1:0] sticky_clear_mask_in,
    // Loss-of-signal source selection
    input wire logic [sgo_pkg::NUM_MODULES-1:0] los_from_gpio_in,
    input wire logic [sgo_pkg::NUM_MODULES-1:0] los_gpio_in,
    // Output values toward the shift engine
    output logic [sgo_pkg::NUM_BITS-1:0] bit_value_out,
    // Status vectors
    output logic [sgo_pkg::NUM_BITS-1:0] sampled_input_vector_out,
    output logic [sgo_pkg::NUM_BITS-1:0] raw_input_irq_vector_out,
    output logic [sgo_pkg::NUM_BITS-1:0] sticky_irq_vector_out,
    output logic [sgo_pkg::NUM_BITS-1:0] active_irq_identity_out,
    output logic irq_out,
    // Loss-of-signal toward port modules
    output logic [sgo_pkg::NUM_MODULES-1:0] los_out
);
    import sgo_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Blink generators

    // Counters start at zero
    localparam logic [TICK_CNT_W-1:0] BLINK_LAST = TICK_CNT_W'(BLINK_HALF_CYCLES - 1);
    localparam logic [TICK_CNT_W-1:0] ACT_LAST = TICK_CNT_W'(ACT_TICK_CYCLES - 1);
    localparam logic [ACT_CNT_W-1:0] ACT_RELOAD = ACT_CNT_W'(ACT_STRETCH_TICKS);
    localparam logic [ACT_CNT_W-1:0] ACT_ZERO = ACT_CNT_W'(0);

    logic [TICK_CNT_W-1:0] blink_cnt_q;
    logic [TICK_CNT_W-1:0] blink_cnt_d;
    logic [BLINK_DIV_W-1:0] blink_div_q;
    logic [BLINK_DIV_W-1:0] blink_div_d;

    logic burst_tgl_q;

    logic blink_tick;

    logic blink0;
    logic blink1;

    // Bit 0 toggles every 25 ms giving 20 Hz; each higher bit halves the rate
    assign blink_tick = (blink_cnt_q == BLINK_LAST);
    assign blink_cnt_d = blink_tick ? '0 : blink_cnt_q + 1'b1;
    assign blink_div_d = blink_tick ? blink_div_q + 1'b1 : blink_div_q;

    // Rate code indexes the divider directly
    assign blink0 = blink_div_q[blink_gen0_rate_in]; // [RULE5]
    assign blink1 = (blink_gen1_rate_in == RATE_SLOW) ? burst_tgl_q
                                                     : blink_div_q[blink_gen1_rate_in]; // [RULE6]

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            blink_cnt_q <= '0;
            blink_div_q <= '0;
        end
        else if (blink_counter_clear_in)
        begin
            // Held clear keeps several controllers phase aligned on release
            blink_cnt_q <= '0; // [RULE7]
            blink_div_q <= '0; // [RULE7]
        end
        else
        begin
            blink_cnt_q <= blink_cnt_d;
            blink_div_q <= blink_div_d;
        end
    end

    // Restarts with the divider
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            burst_tgl_q <= 1'b0;
        else if (blink_counter_clear_in)
            burst_tgl_q <= 1'b0;
        else if (burst_done_in)
            burst_tgl_q <= ~burst_tgl_q; // [RULE6]
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Activity envelopes

    logic [TICK_CNT_W-1:0] act_cnt_q;
    logic act_tick;
    logic [NUM_MODULES-1:0] act_pulse;

    logic [NUM_MODULES-1:0] envelope;

    logic [NUM_PORTS-1:0] port_env;

    assign act_tick = (act_cnt_q == ACT_LAST);

    assign act_pulse = rx_activity_in | tx_activity_in;

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            act_cnt_q <= '0;
        else
            act_cnt_q <= act_tick ? '0 : act_cnt_q + 1'b1;
    end

    // One extra tick of reload covers the unknown phase of the shared tick
    for (genvar m = 0; m < NUM_MODULES; m++)
    begin : g_env
        logic [ACT_CNT_W-1:0] stretch_q;
        logic [ACT_CNT_W-1:0] stretch_d;

        assign stretch_d = act_pulse[m] ? ACT_RELOAD // [RULE9]
                         : (act_tick && stretch_q != ACT_ZERO) ? stretch_q - 1'b1
                         : stretch_q;

        assign envelope[m] = (stretch_q != ACT_ZERO);
        always_ff @(posedge mclk_in or negedge nrst_in)
        begin
            if (!nrst_in)
                stretch_q <= '0;
            else
                stretch_q <= stretch_d;
        end
    end

    // Ports above the mapped range never see activity
    assign port_env = {{(NUM_PORTS - NUM_MODULES){1'b0}}, envelope}; // [RULE10]

    ////////////////////////////////////////////////////////////////////////////////
    // Per-bit output selection

    logic [NUM_BITS-1:0] bit_value_d;
    logic [NUM_BITS-1:0] bit_value_q;

    for (genvar b = 0; b < NUM_BITS; b++)
    begin : g_out
        sgo_bitcfg_t cfg;
        logic env;
        logic pat;
        logic src_val;
        logic pwm_val;

        assign cfg = bit_cfg_in[b];
        assign env = port_env[b / BITS_PER_PORT];
        assign pat = cfg.src[0] ? blink1 : blink0; // [RULE4]

        always_comb
        begin
            src_val = 1'b0;
            unique case (cfg.src) // [RULE1]
                SRC_STATIC0: src_val = 1'b0; // [RULE3]
                SRC_STATIC1: src_val = 1'b1; // [RULE3]
                SRC_BLINK0, SRC_BLINK1: src_val = pat;
                SRC_ACT_BLINK0, SRC_ACT_BLINK1: src_val = env & pat; // [RULE8]
                SRC_ACT_INV_BLINK0, SRC_ACT_INV_BLINK1: src_val = ~(env & pat); // [RULE11]
            endcase
        end

        // Select 0 means no PWM modulation
        assign pwm_val = (cfg.pwm_sel == 2'h0) ? 1'b1 : pwm_in[cfg.pwm_sel - 2'h1];
        assign bit_value_d[b] = (src_val & pwm_val) ^ cfg.invert; // [RULE2]
    end

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            bit_value_q <= '0;
        else
            bit_value_q <= bit_value_d;
    end

    // Flopped toward the engine
    assign bit_value_out = bit_value_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial input capture

    logic sdi_s1_q;
    logic sdi_s2_q;
    logic sdi_s3_q;
    logic sdi_q;

    logic sdi_d;

    logic [NUM_BITS-1:0] sampled_q;

    // Pin glitches are rejected until two stages agree
    assign sdi_d = (sdi_s2_q == sdi_s3_q) ? sdi_s2_q : sdi_q;

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sdi_s1_q <= 1'b0;
            sdi_s2_q <= 1'b0;
            sdi_s3_q <= 1'b0;
            sdi_q <= 1'b0;
        end
        else
        begin
            sdi_s1_q <= serial_data_in;
            sdi_s2_q <= sdi_s1_q;
            sdi_s3_q <= sdi_s2_q;
            sdi_q <= sdi_d;
        end
    end

    // Engine strobes at its sample point; synchroniser latency is its to absorb
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            sampled_q <= '0;
        else if (sample_in.strobe)
        begin
            sampled_q[sample_in.index] <= sdi_d; // [RULE23]
        end
    end

    assign sampled_input_vector_out = sampled_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt vectors

    logic [NUM_BITS-1:0] raw_q;
    logic [NUM_BITS-1:0] raw_d;
    logic [NUM_BITS-1:0] raw_prev_q;

    logic [NUM_BITS-1:0] trig_hit;

    logic [NUM_BITS-1:0] sticky_q;
    logic [NUM_BITS-1:0] sticky_d;
    logic [NUM_BITS-1:0] clr;

    logic [NUM_BITS-1:0] en_mask;
    logic [NUM_BITS-1:0] ident_q;
    logic [NUM_BITS-1:0] ident_d;

    logic irq_q;

    assign raw_d = sampled_q ^ input_polarity_vector_in; // [RULE15]

    for (genvar b = 0; b < NUM_BITS; b++)
    begin : g_trig
        logic [1:0] mode;
        assign mode = {trigger_select_hi_in[b], trigger_select_lo_in[b]};

        always_comb
        begin
            trig_hit[b] = 1'b0;
            unique case (mode) // [RULE16]
                TRIG_LEVEL: trig_hit[b] = raw_q[b];
                TRIG_ANY: trig_hit[b] = raw_q[b] ^ raw_prev_q[b];
                TRIG_FALL: trig_hit[b] = ~raw_q[b] & raw_prev_q[b];
                TRIG_RISE: trig_hit[b] = raw_q[b] & ~raw_prev_q[b];
            endcase
        end

        assign en_mask[b] = port_irq_enable_in[b / BITS_PER_PORT]
                          & position_irq_enable_in[b % BITS_PER_PORT]; // [RULE13]
    end

    // A new event wins over a clear in the same cycle
    assign clr = sticky_clear_we_in ? sticky_clear_mask_in : '0;
    assign sticky_d = (sticky_q & ~clr) | trig_hit; // [RULE17]
    assign ident_d = sticky_d & en_mask; // [RULE18]

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            raw_q <= '0;
            raw_prev_q <= '0;
            sticky_q <= '0;
            ident_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            raw_q <= raw_d; // [RULE14]
            raw_prev_q <= raw_q;
            sticky_q <= sticky_d; // [RULE14]
            ident_q <= ident_d; // [RULE18]
            irq_q <= |ident_d; // [RULE19] [RULE12]
        end
    end

    // Flopped, so the line never glitches
    assign raw_input_irq_vector_out = raw_q;
    assign sticky_irq_vector_out = sticky_q;
    assign active_irq_identity_out = ident_q;
    assign irq_out = irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Loss-of-signal forwarding

    logic [NUM_MODULES-1:0] los_d;

    logic [NUM_MODULES-1:0] los_q;

    for (genvar m = 0; m < NUM_MODULES; m++)
    begin : g_los
        localparam int LB = m * BITS_PER_PORT + LOS_BIT;

        assign los_d[m] = los_from_gpio_in[m] ? los_gpio_in[m] // [RULE21]
                        : sampled_q[LB] ^ input_polarity_vector_in[LB]; // [RULE20] [RULE22]
    end

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            los_q <= '0;
        else
            los_q <= los_d; // [RULE10]
    end

    assign los_out = los_q;
endmodule // sgo_top

// [src/sgo_pkg.sv]
// Constants, types and configuration encodings for the serial GPIO output and interrupt block
//
// Function
// [RULE1] Each output bit picks static, blink or link-activity as its source.
// [RULE2] The chosen source is gated by a selectable PWM input and a per-bit inversion.
// [RULE3] Static source drives a constant 0 or 1 chosen by software.
// [RULE4] Two blink generators exist; each blinking bit picks generator 0 or 1.
// [RULE5] Generator 0 codes 0..3 give 20, 10, 5 and 2.5 Hz.
// [RULE6] Generator 1 codes 0..2 give 20, 10, 5 Hz; code 3 toggles per burst.
// [RULE7] Blink counter clear resets the counters; software clears all controllers together.
// [RULE8] Activity mode gates the blink pattern with an envelope; no envelope means off.
// [RULE9] Activity stretches to at least 100 ms; a new packet extends by 100 ms.
// [RULE10] Serial ports 0 to 10 map to port modules 0 to 10; others unmapped.
// [RULE11] The source field also selects the polarity of the activity output.
// [RULE12] Interrupts come from sampled inputs; the interrupt output is a level.
// [RULE13] Interrupts are qualified by a 32-bit port enable and 4-bit position enable.
// [RULE14] Raw, sticky, identity and polarity vectors each hold 128 bits.
// [RULE15] Raw bit equals polarity-corrected input bit and follows it without latching.
// [RULE16] Two trigger vectors pick level, any edge, falling or rising per bit.
// [RULE17] Sticky bits hold until software writes 1 to clear; 0 leaves them.
// [RULE18] Identity is sticky masked by both enables, updated on any change.
// [RULE19] One interrupt line stays high while any identity bit is set.
// [RULE20] Bit 0 of each serial port feeds the matching port module loss-of-signal.
// [RULE21] A module taking loss-of-signal from a regular GPIO ignores the serial value.
// [RULE22] The forwarded loss-of-signal value uses the bit 0 interrupt polarity.
// [RULE23] Serial data input is sampled during bursts and shown as the input vector.
package sgo_pkg;
    localparam int NUM_PORTS = 32;
    localparam int BITS_PER_PORT = 4;
    localparam int NUM_BITS = NUM_PORTS * BITS_PER_PORT;
    localparam int NUM_MODULES = 11;
    localparam int NUM_PWM = 3;
    localparam int IDX_W = 7;
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int BLINK_HALF_US = 25000;
    localparam int BLINK_HALF_CYC = BLINK_HALF_US * CLK_MHZ;
    localparam int ACT_TICK_US = 1000;
    localparam int ACT_TICK_CYC = ACT_TICK_US * CLK_MHZ;
    localparam int ACT_STRETCH_MS = 100;
    localparam int ACT_STRETCH_TICKS = (ACT_STRETCH_MS * 1000) / ACT_TICK_US + 1;
    localparam int ACT_CNT_W = 7;
    localparam int TICK_CNT_W = 32;
    // Blink rate codes
    localparam logic [1:0] RATE_20HZ = 2'h0;
    localparam logic [1:0] RATE_10HZ = 2'h1;
    localparam logic [1:0] RATE_5HZ = 2'h2;
    localparam logic [1:0] RATE_SLOW = 2'h3;
    localparam int BLINK_DIV_W = 4;
    // Trigger codes {hi, lo}
    localparam logic [1:0] TRIG_LEVEL = 2'h0;
    localparam logic [1:0] TRIG_ANY = 2'h1;
    localparam logic [1:0] TRIG_FALL = 2'h2;
    localparam logic [1:0] TRIG_RISE = 2'h3;
    localparam int LOS_BIT = 0;

    typedef enum logic [2:0] {
        SRC_STATIC0,
        SRC_STATIC1,
        SRC_BLINK0,
        SRC_BLINK1,
        SRC_ACT_BLINK0,
        SRC_ACT_BLINK1,
        SRC_ACT_INV_BLINK0,
        SRC_ACT_INV_BLINK1
    } sgo_src_t;

    typedef struct packed {
        sgo_src_t src;
        logic [1:0] pwm_sel;
        logic invert;
    } sgo_bitcfg_t;

    typedef struct packed {
        logic strobe;
        logic [IDX_W-1:0] index;
    } sgo_sample_t;
endpackage

// [testbench/sgo_chain_model.sv]
// Behavioural input side of the external shift-register chain
`timescale 1ns/100ps
module sgo_chain_model (
    // Parallel values held in the chain
    input wire logic [sgo_pkg::NUM_BITS-1:0] pattern_in,
    // Position currently shifted out
    input wire logic [sgo_pkg::IDX_W-1:0] index_in,
    // Serial data toward the controller
    output logic serial_data_out
);
    import sgo_pkg::*;
    // Chain drives the line at all times, so it never floats
    assign serial_data_out = pattern_in[index_in];
endmodule // sgo_chain_model

// [testbench/sgo_top_props.sv]
// Concurrent checks on the serial GPIO block ports
`timescale 1ns/100ps
module sgo_top_props (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Watched inputs
    input wire sgo_pkg::sgo_bitcfg_t [sgo_pkg::NUM_BITS-1:0] bit_cfg_in,
    input wire logic blink_counter_clear_in,
    input wire logic [sgo_pkg::NUM_PWM-1:0] pwm_in,
    input wire logic [sgo_pkg::NUM_BITS-1:0] input_polarity_vector_in,
    input wire logic [sgo_pkg::NUM_BITS-1:0] trigger_select_lo_in,
    input wire logic [sgo_pkg::NUM_BITS-1:0] trigger_select_hi_in,
    input wire logic [sgo_pkg::NUM_PORTS-1:0] port_irq_enable_in,
    input wire logic [sgo_pkg::BITS_PER_PORT-1:0] position_irq_enable_in,
    input wire logic sticky_clear_we_in,
    input wire logic [sgo_pkg::NUM_BITS-1:0] sticky_clear_mask_in,
    input wire logic [sgo_pkg::NUM_MODULES-1:0] los_from_gpio_in,
    input wire logic [sgo_pkg::NUM_MODULES-1:0] los_gpio_in,
    // Watched outputs
    input wire logic [sgo_pkg::NUM_BITS-1:0] bit_value_out,
    input wire logic [sgo_pkg::NUM_BITS-1:0] sampled_input_vector_out,
    input wire logic [sgo_pkg::NUM_BITS-1:0] raw_input_irq_vector_out,
    input wire logic [sgo_pkg::NUM_BITS-1:0] sticky_irq_vector_out,
    input wire logic [sgo_pkg::NUM_BITS-1:0] active_irq_identity_out,
    input wire logic irq_out,
    input wire logic [sgo_pkg::NUM_MODULES-1:0] los_out
);
    import sgo_pkg::*;
    logic live_q;
    logic static_exp;
    logic [NUM_BITS-1:0] en_mask, cond_d, cond_q, prev_q, hi, lo, r, st;
    logic [NUM_MODULES-1:0] los_exp;
    ////////////////////////////////////////////////////////////////////////////////
    for (genvar b = 0; b < NUM_BITS; b++)
    begin : g_en
        assign en_mask[b] = port_irq_enable_in[b / 4] & position_irq_enable_in[b % 4];
    end
    for (genvar m = 0; m < NUM_MODULES; m++)
    begin : g_los
        assign los_exp[m] = los_from_gpio_in[m] ? los_gpio_in[m]
            : sampled_input_vector_out[4 * m] ^ input_polarity_vector_in[4 * m];
    end
    assign hi = trigger_select_hi_in;
    assign lo = trigger_select_lo_in;
    assign r = raw_input_irq_vector_out;
    assign st = sticky_irq_vector_out;
    assign cond_d = (~hi & ~lo & r) | (~hi & lo & (r ^ prev_q))
        | (hi & ~lo & ~r & prev_q) | (hi & lo & r & ~prev_q);
    assign static_exp = (bit_cfg_in[0].src[0] & ((bit_cfg_in[0].pwm_sel == 2'h0) ? 1'h1
        : pwm_in[bit_cfg_in[0].pwm_sel - 2'h1])) ^ bit_cfg_in[0].invert;
    ////////////////////////////////////////////////////////////////////////////////
    // Trigger reference lags one edge so it lines up with the sticky flops
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            live_q <= 1'h0;
            prev_q <= '0;
            cond_q <= '0;
        end
        else
        begin
            live_q <= 1'h1;
            prev_q <= r;
            cond_q <= cond_d;
        end
    end
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);
    sequence clr_held;
        blink_counter_clear_in [*3];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    static_bit_a: assert property (live_q && $past(bit_cfg_in[0].src[2:1] == 2'h0)
        |-> bit_value_out[0] == $past(static_exp)) else $error("static bit value wrong");
    unmapped_act_a: assert property (live_q && $past(bit_cfg_in[44]) == 6'h28
        |-> !bit_value_out[44]) else $error("unmapped port shows activity");
    blink_clear_a: assert property ((clr_held ##0 $past(bit_cfg_in[1]) == 6'h10)
        |-> !bit_value_out[1]) else $error("blink runs while cleared");
    raw_follow_a: assert property (live_q
        |-> r == $past(sampled_input_vector_out ^ input_polarity_vector_in))
        else $error("raw vector wrong");
    sticky_set_a: assert property ((cond_q & ~st) == '0)
        else $error("trigger did not set sticky");
    sticky_cause_a: assert property (live_q |-> (st & ~$past(st) & ~cond_q) == '0)
        else $error("sticky set without trigger");
    sticky_hold_a: assert property (live_q |-> (~st & $past(st)
        & ~({NUM_BITS{$past(sticky_clear_we_in)}} & $past(sticky_clear_mask_in))) == '0)
        else $error("sticky lost without clear");
    ident_mask_a: assert property (live_q
        |-> active_irq_identity_out == (st & $past(en_mask))) else $error("identity wrong");
    irq_level_a: assert property (irq_out == (|active_irq_identity_out))
        else $error("interrupt line wrong");
    los_fwd_a: assert property (live_q |-> los_out == $past(los_exp))
        else $error("loss of signal wrong");
endmodule // sgo_top_props

// [testbench/sgo_top_test.sv]
// Self-checking bench for the serial GPIO output, interrupt and loss-of-signal block
`timescale 1ns/100ps
module sgo_top_test;
    import sgo_pkg::*;
    typedef struct packed {sgo_bitcfg_t cfg; logic [2:0] pwm; logic exp;} sgo_row_t;
    localparam sgo_row_t ROWS [7] = '{'{6'h00, 3'h5, 1'h0}, '{6'h08, 3'h5, 1'h1},
        '{6'h09, 3'h5, 1'h0}, '{6'h01, 3'h5, 1'h1}, '{6'h0A, 3'h5, 1'h1},
        '{6'h0C, 3'h5, 1'h0}, '{6'h0F, 3'h5, 1'h0}};
    logic mclk_in = 1'h0, nrst_in = 1'h0, blink_counter_clear_in = 1'h1, burst_done_in = 1'h0;
    logic sticky_clear_we_in = 1'h0, serial_data_in, irq_out;
    logic [1:0] blink_gen0_rate_in = 2'h0, blink_gen1_rate_in = 2'h0;
    logic [2:0] pwm_in = 3'h0;
    logic [10:0] rx_activity_in = '0, tx_activity_in = '0, los_from_gpio_in = '0;
    logic [10:0] los_gpio_in = '0, los_out;
    logic [IDX_W-1:0] cap_idx = '0;
    logic [31:0] port_irq_enable_in = 32'h8;
    logic [3:0] position_irq_enable_in = 4'hF;
    logic [NUM_BITS-1:0] input_polarity_vector_in = '0, trigger_select_lo_in = '0;
    logic [NUM_BITS-1:0] trigger_select_hi_in = '0, sticky_clear_mask_in = '0, pattern = '0;
    logic [NUM_BITS-1:0] bit_value_out, sampled_input_vector_out, raw_input_irq_vector_out;
    logic [NUM_BITS-1:0] sticky_irq_vector_out, active_irq_identity_out;
    sgo_bitcfg_t [NUM_BITS-1:0] bit_cfg_in = '0;
    sgo_sample_t sample_in = '0;
    int n_fail = 0, total_checks = 0, cycles = 0, n;
    ////////////////////////////////////////////////////////////////////////////////
    sgo_top #(.BLINK_HALF_CYCLES(8), .ACT_TICK_CYCLES(4)) i_dut (.mclk_in, .nrst_in,
        .bit_cfg_in, .blink_gen0_rate_in, .blink_gen1_rate_in, .blink_counter_clear_in,
        .pwm_in, .burst_done_in, .rx_activity_in, .tx_activity_in, .serial_data_in,
        .sample_in, .input_polarity_vector_in, .trigger_select_lo_in, .trigger_select_hi_in,
        .port_irq_enable_in, .position_irq_enable_in, .sticky_clear_we_in,
        .sticky_clear_mask_in, .los_from_gpio_in, .los_gpio_in, .bit_value_out,
        .sampled_input_vector_out, .raw_input_irq_vector_out, .sticky_irq_vector_out,
        .active_irq_identity_out, .irq_out, .los_out);
    sgo_chain_model i_chain (.pattern_in(pattern), .index_in(cap_idx),
        .serial_data_out(serial_data_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic look(input int k);
        repeat (k) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask
    task automatic check(input logic [NUM_BITS-1:0] seen, input logic [NUM_BITS-1:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %0h, expected %0h", $time, seen, exp);
        end
    endtask
    task automatic blink(input int b, input int k);
        @(posedge mclk_in);
        blink_counter_clear_in <= 1'h1;
        blink_gen0_rate_in <= 2'(k);
        blink_gen1_rate_in <= 2'(k);
        look(3);
        check(bit_value_out[b], 1'h0);
        @(posedge mclk_in);
        blink_counter_clear_in <= 1'h0;
        for (n = 0; n < 300 && bit_value_out[b] !== 1'h1; n++)
            @(negedge mclk_in);
        check(n >= (8 << k) - 1 && n <= (8 << k) + 2, 1'h1);
    endtask
    // Pin filter needs a few cycles before the strobe takes the new level
    task automatic cap(input int b, input logic v);
        @(posedge mclk_in);
        pattern[b] <= v;
        cap_idx <= IDX_W'(b);
        repeat (6) @(posedge mclk_in);
        sample_in <= '{1'h1, IDX_W'(b)};
        @(posedge mclk_in);
        sample_in <= '0;
    endtask
    task automatic clr(input logic [3:0] m);
        @(posedge mclk_in);
        sticky_clear_we_in <= 1'h1;
        sticky_clear_mask_in[15:12] <= m;
        @(posedge mclk_in);
        sticky_clear_we_in <= 1'h0;
        look(1);
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            summarize();
        end
    end
    initial
    begin
        bit_cfg_in[1] = 6'h10;
        bit_cfg_in[2] = 6'h18;
        bit_cfg_in[4] = 6'h28;
        bit_cfg_in[5] = 6'h38;
        bit_cfg_in[44] = 6'h28;
        trigger_select_hi_in[15:12] = 4'hC;
        trigger_select_lo_in[15:12] = 4'hA;
        repeat (3) @(posedge mclk_in);
        nrst_in <= 1'h1;
        foreach (ROWS[i])
        begin
            @(posedge mclk_in);
            bit_cfg_in[0] <= ROWS[i].cfg;
            pwm_in <= ROWS[i].pwm;
            look(1);
            check(bit_value_out[0], ROWS[i].exp);
        end
        for (int k = 0; k < 4; k++)
        begin
            blink(1, k);
            if (k < 3)
                blink(2, k);
        end
        @(posedge mclk_in);
        blink_gen1_rate_in <= 2'h3;
        blink_counter_clear_in <= 1'h1;
        @(posedge mclk_in);
        blink_counter_clear_in <= 1'h0;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge mclk_in);
            burst_done_in <= 1'h1;
            @(posedge mclk_in);
            burst_done_in <= 1'h0;
            look(2);
            check(bit_value_out[2], i % 2 == 0);
        end
        check(bit_value_out[5:4], 2'h2);
        @(posedge mclk_in);
        rx_activity_in <= 11'h002;
        @(posedge mclk_in);
        rx_activity_in <= '0;
        look(3);
        check(bit_value_out[5:4], 2'h1);
        repeat (340) @(posedge mclk_in);
        tx_activity_in <= 11'h002;
        @(posedge mclk_in);
        tx_activity_in <= '0;
        for (n = 0; n < 600 && bit_value_out[4] === 1'h1; n++)
            @(negedge mclk_in);
        check(n >= 400 && n <= 408, 1'h1);
        check(bit_value_out[44], 1'h0);
        for (int b = 12; b < 16; b++)
            cap(b, 1'h1);
        look(3);
        check(raw_input_irq_vector_out[15:12], 4'hF);
        check(sampled_input_vector_out[15:12], 4'hF);
        check({irq_out, sticky_irq_vector_out[15:12]}, 5'h1B);
        @(posedge mclk_in);
        port_irq_enable_in <= '0;
        look(2);
        check({irq_out, active_irq_identity_out[15:12]}, 5'h00);
        @(posedge mclk_in);
        port_irq_enable_in <= 32'h8;
        position_irq_enable_in <= 4'h2;
        look(2);
        check({irq_out, active_irq_identity_out[15:12]}, 5'h12);
        clr(4'hF);
        check({irq_out, sticky_irq_vector_out[15:12]}, 5'h01);
        for (int b = 12; b < 16; b++)
            cap(b, 1'h0);
        look(3);
        check(sticky_irq_vector_out[15:12], 4'h7);
        clr(4'h0);
        check({irq_out, sticky_irq_vector_out[15:12]}, 5'h17);
        clr(4'hF);
        check({irq_out, sticky_irq_vector_out[15:12]}, 5'h00);
        @(posedge mclk_in);
        input_polarity_vector_in[12] <= 1'h1;
        look(2);
        check({los_out[3], raw_input_irq_vector_out[12]}, 2'h3);
        @(posedge mclk_in);
        los_from_gpio_in[3] <= 1'h1;
        look(1);
        check(los_out[3], 1'h0);
        @(posedge mclk_in);
        los_from_gpio_in[3] <= 1'h0;
        input_polarity_vector_in[12] <= 1'h0;
        cap(12, 1'h1);
        look(2);
        check(los_out[3:0], 4'h8);
        @(posedge mclk_in);
        nrst_in <= 1'h0;
        look(1);
        check({irq_out, los_out, sticky_irq_vector_out[12]}, 13'h0);
        @(posedge mclk_in);
        nrst_in <= 1'h1;
        look(2);
        check({los_out[3], sampled_input_vector_out[12]}, 2'h0);
        summarize();
    end
endmodule // sgo_top_test
bind sgo_top sgo_top_props i_props (.mclk_in, .nrst_in, .bit_cfg_in, .blink_counter_clear_in,
    .pwm_in, .input_polarity_vector_in, .trigger_select_lo_in, .trigger_select_hi_in,
    .port_irq_enable_in, .position_irq_enable_in, .sticky_clear_we_in, .sticky_clear_mask_in,
    .los_from_gpio_in, .los_gpio_in, .bit_value_out, .sampled_input_vector_out,
    .raw_input_irq_vector_out, .sticky_irq_vector_out, .active_irq_identity_out, .irq_out,
    .los_out);
